// >>> pkg/ebw_pkg.sv
// Constants for the external bus wait-state and bank-switch block.
// Assumes a 32-bit APB master and a 25 MHz pclk.
package ebw_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  EBW_IDX_WAIT_CFG   = 8'h28;
  localparam logic [7:0]  EBW_IDX_BANK_CTL   = 8'h29;
  localparam logic [7:0]  EBW_IDX_WAIT_CTL   = 8'h2b;
  localparam logic [7:0]  EBW_IDX_STATUS     = 8'h2c;

  // Wait-state configuration fields
  localparam int unsigned EBW_XPA_BIT        = 15;
  localparam int unsigned EBW_IO_LSB         = 12;
  localparam int unsigned EBW_DHI_LSB        = 9;
  localparam int unsigned EBW_DLO_LSB        = 6;
  localparam int unsigned EBW_PHI_LSB        = 3;
  localparam int unsigned EBW_PLO_LSB        = 0;
  localparam int unsigned EBW_FIELDS_MSB     = 14;
  localparam logic [15:0] EBW_WAIT_CFG_RST   = 16'h7fff;

  // Wait-state control fields
  localparam int unsigned EBW_MULT_BIT       = 0;
  localparam logic        EBW_MULT_RST       = 1'b0;

  // Bank-switch control fields
  localparam int unsigned EBW_CONSECUTIVE_BANK_MODE_BIT     = 15;
  localparam int unsigned EBW_DIV_LSB        = 13;
  localparam int unsigned EBW_IACKOFF_BIT    = 12;
  localparam logic        EBW_CONSECUTIVE_BANK_MODE_RST     = 1'b0;
  localparam logic [1:0]  EBW_DIV_RST        = 2'h3;
  localparam logic        EBW_IACKOFF_RST    = 1'b1;

  // Status fields
  localparam int unsigned EBW_ST_GATED_BIT   = 0;
  localparam int unsigned EBW_ST_BUSY_BIT    = 1;

  // Address layout
  localparam int unsigned EBW_AW             = 23;
  localparam int unsigned EBW_DW             = 16;
  localparam int unsigned EBW_BANK_BIT       = 15;
  localparam int unsigned EBW_XBANK_BIT      = 22;
  localparam int unsigned EBW_PAGE_LSB       = 16;

  typedef enum logic [1:0]
  {
    EBW_SP_PROG = 2'h0,
    EBW_SP_DATA = 2'h1,
    EBW_SP_IO   = 2'h2
  } ebw_space_t;

  typedef enum logic [4:0]
  {
    EBW_ST_IDLE  = 5'h01,
    EBW_ST_GAP   = 5'h02,
    EBW_ST_STRB  = 5'h04,
    EBW_ST_TRAIL = 5'h08,
    EBW_ST_DONE  = 5'h10
  } ebw_state_t;

endpackage

// >>> pkg/ebw_cfg_if.sv
// Carrier between the controller and its wait-count selector.
// Assumes both ends run on the same pclk.
interface ebw_cfg_if;
  import ebw_pkg::*;

  logic [15:0]       wait_cfg;
  logic              wait_multiplier;
  ebw_space_t        space;
  logic [EBW_AW-1:0] addr;
  logic [3:0]        wait_count;
  logic              gen_off;

  modport ctl
  (
    output wait_cfg,
    output wait_multiplier,
    output space,
    output addr,
    input  wait_count,
    input  gen_off
  );

  modport sel
  (
    input  wait_cfg,
    input  wait_multiplier,
    input  space,
    input  addr,
    output wait_count,
    output gen_off
  );
endinterface

// >>> hw/ebw_wait_sel.sv
// Range decode: picks the base wait count for an access and scales it.
// Assumes the controller's address and space, taken straight from the core in the take cycle.
module ebw_wait_sel
  import ebw_pkg::*;
(
  // Configuration and access
  ebw_cfg_if.sel cfg
);

  wire       extended_program_range_sel;
  wire       prog_hi;
  wire [2:0] io_f;
  wire [2:0] dhi_f;
  wire [2:0] dlo_f;
  wire [2:0] phi_f;
  wire [2:0] plo_f;
  wire [2:0] base;

  assign extended_program_range_sel   = cfg.wait_cfg[EBW_XPA_BIT];
  assign io_f  = cfg.wait_cfg[EBW_IO_LSB +: 3];
  assign dhi_f = cfg.wait_cfg[EBW_DHI_LSB +: 3];
  assign dlo_f = cfg.wait_cfg[EBW_DLO_LSB +: 3];
  assign phi_f = cfg.wait_cfg[EBW_PHI_LSB +: 3];
  assign plo_f = cfg.wait_cfg[EBW_PLO_LSB +: 3];

  // Program range split depends on the extended range select
  assign prog_hi = extended_program_range_sel ? cfg.addr[EBW_XBANK_BIT]
                       : cfg.addr[EBW_BANK_BIT];

  assign base =
    (cfg.space == EBW_SP_IO)   ? io_f :
    (cfg.space == EBW_SP_DATA) ? (cfg.addr[EBW_BANK_BIT] ? dhi_f : dlo_f) :
    (prog_hi ? phi_f : plo_f);

  assign cfg.wait_count = cfg.wait_multiplier ? {base, 1'b0}
                                              : {1'b0, base};
  assign cfg.gen_off = (cfg.wait_cfg[EBW_FIELDS_MSB:0] == 15'h0000);

endmodule

// >>> hw/ebw_clkdiv.sv
// Bus clock output divider; tick marks the end of each bus clock cycle.
// Assumes divfct is a register value from the same clock domain.
module ebw_clkdiv
  import ebw_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [1:0] divfct,
  // Outputs
  output logic            tick,
  output logic            bus_clock_output
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       clk_r;

  assign tick    = (cnt_r >= divfct);
  assign cnt_nxt = tick ? 2'h0 : 2'(cnt_r + 2'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 2'h0;
      clk_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      clk_r <= (cnt_nxt == 2'h0) ? 1'b1 : ~clk_r & (divfct == 2'h0);
    end
  end

  assign bus_clock_output = clk_r;

endmodule

// >>> hw/ebw_top.sv
// External bus cycle controller: wait states, ready extension, bank gaps.
// Assumes an APB master on pclk, a core access port on pclk, and
// asynchronous external ready and data pins.
//
// Behaviour
// - Each external cycle can be stretched by up to fourteen programmed waits.
// - A slow device holds ready low to stretch beyond the programmed waits.
// - All range counts zero turns the wait-state generator off.
// - Low 15 config bits hold five 3-bit base counts, 0 to 7.
// - Multiplier 0 keeps base counts; 1 doubles them, up to 14.
// - After reset every range gives seven waits, multiplier cleared.
// - Bits 14-12 give the I/O space base count.
// - Bits 11-9 give the upper data space base count.
// - Bits 8-6 give the lower data space base count.
// - Bits 5-3 give upper program space, split per extended range select.
// - Bits 2-0 give lower program space, split per extended range select.
// - Bit 15 selects program range mapping and resets to zero.
// - Control register bits 15-1 read zero; only the multiplier is writable.
// - A program or data read crossing a 32K-word bank boundary inserts one extra bus cycle.
// - Consecutive mode makes every program or data read start, read, and trail cycles.
// - Otherwise a read to another bank idles the strobe one bus clock.
// - Program/data read changes and program page changes also add a cycle.
//
// The APB register port was decided locally.
module ebw_top
  import ebw_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core access port
  input  wire logic              acc_req,
  input  wire logic [1:0]        acc_space,
  input  wire logic              acc_write,
  input  wire logic [EBW_AW-1:0] acc_addr,
  input  wire logic [EBW_DW-1:0] acc_wdata,
  output logic                   acc_ack,
  output logic                   acc_done,
  output logic [EBW_DW-1:0]      acc_rdata,
  // External bus
  output logic [EBW_AW-1:0]      ext_addr,
  output logic                   ext_read,
  output logic                   memory_strobe_n,
  output logic                   io_strobe_n,
  output logic [EBW_DW-1:0]      ext_data_o,
  output logic                   ext_data_oe,
  input  wire logic [EBW_DW-1:0] ext_data_i,
  input  wire logic              ext_ready,
  output logic                   bus_clock_output,
  output logic                   iack_off
);

  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [7:0]  idx);
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // Registers
  logic [15:0]       wait_cfg_r;
  logic              wait_multiplier_r;
  logic              consecutive_bank_mode_r;
  logic [1:0]        divfct_r;
  logic              iackoff_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;

  // Bus tracking and access state
  ebw_state_t        state_r;
  ebw_state_t        state_nxt;
  logic [3:0]        wcnt_r;
  logic [3:0]        wcnt_nxt;
  logic [EBW_AW-1:0] addr_r;
  ebw_space_t        space_r;
  logic              write_r;
  logic [EBW_DW-1:0] wdata_r;
  logic [EBW_DW-1:0] rdata_r;
  logic              last_valid_r;
  logic              last_read_r;
  logic              last_prog_r;
  logic              last_msb_r;
  logic [6:0]        last_page_r;
  logic [1:0]        age_r;

  // Pin synchronisers
  logic              rdy_s1_r;
  logic              rdy_s2_r;
  logic [EBW_DW-1:0] din_s1_r;
  logic [EBW_DW-1:0] din_s2_r;

  wire               setup_ph;
  wire               wr_en;
  wire               hit_cfg;
  wire               hit_bank;
  wire               hit_ctl;
  wire               hit_st;
  wire               hit_any;
  wire [31:0]        rd_mux;
  wire               take;
  wire               is_read;
  wire               is_mem;
  wire               cross_bank;
  wire               cross_space;
  wire               cross_page;
  wire               need_gap;
  wire               wait_over;
  wire               settled;
  wire               finish;
  wire               strobe_on;
  wire               tick;

  ebw_cfg_if cfg_bus ();

  ebw_wait_sel u_sel
  (
    .cfg (cfg_bus.sel)
  );

  ebw_clkdiv u_div
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .divfct           (divfct_r),
    .tick             (tick),
    .bus_clock_output (bus_clock_output)
  );

  assign cfg_bus.wait_cfg        = wait_cfg_r;
  assign cfg_bus.wait_multiplier = wait_multiplier_r;
  // Incoming request decodes its own range in the take cycle
  assign cfg_bus.space = take ? ebw_space_t'(acc_space) : space_r;
  assign cfg_bus.addr  = take ? acc_addr : addr_r;

  // APB decode
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign hit_cfg  = reg_hit(paddr, EBW_IDX_WAIT_CFG);
  assign hit_bank = reg_hit(paddr, EBW_IDX_BANK_CTL);
  assign hit_ctl  = reg_hit(paddr, EBW_IDX_WAIT_CTL);
  assign hit_st   = reg_hit(paddr, EBW_IDX_STATUS);
  assign hit_any  = hit_cfg | hit_bank | hit_ctl | hit_st;

  assign rd_mux =
    hit_cfg  ? {16'h0000, wait_cfg_r} :
    hit_bank ? {16'h0000, consecutive_bank_mode_r, divfct_r, iackoff_r,
                12'h000} :
    hit_ctl  ? {31'h00000000, wait_multiplier_r} :
    hit_st   ? {30'h00000000, (state_r != EBW_ST_IDLE),
                cfg_bus.gen_off} :
    32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_r <= ~hit_any;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = pslverr_r;

  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cfg_r              <= EBW_WAIT_CFG_RST;
      wait_multiplier_r       <= EBW_MULT_RST;
      consecutive_bank_mode_r <= EBW_CONSECUTIVE_BANK_MODE_RST;
      divfct_r                <= EBW_DIV_RST;
      iackoff_r               <= EBW_IACKOFF_RST;
    end
    else if (wr_en)
    begin
      if (hit_cfg)
        wait_cfg_r <= pwdata[15:0];
      if (hit_ctl)
        wait_multiplier_r <= pwdata[EBW_MULT_BIT];
      if (hit_bank)
      begin
        consecutive_bank_mode_r <= pwdata[EBW_CONSECUTIVE_BANK_MODE_BIT];
        divfct_r                <= pwdata[EBW_DIV_LSB +: 2];
        iackoff_r               <= pwdata[EBW_IACKOFF_BIT];
      end
    end
  end

  assign iack_off = iackoff_r;

  // Ready and data pins pass two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
      din_s1_r <= '0;
      din_s2_r <= '0;
    end
    else
    begin
      rdy_s1_r <= ext_ready;
      rdy_s2_r <= rdy_s1_r;
      din_s1_r <= ext_data_i;
      din_s2_r <= din_s1_r;
    end
  end

  // Gap decision against the previous program/data access
  assign take        = (state_r == EBW_ST_IDLE) & acc_req;
  assign is_read     = ~acc_write;
  assign is_mem      = (acc_space != EBW_SP_IO);
  assign cross_bank  = last_msb_r != acc_addr[EBW_BANK_BIT];
  assign cross_space = last_prog_r != (acc_space == EBW_SP_PROG);
  assign cross_page  = last_prog_r & (acc_space == EBW_SP_PROG)
                     & (last_page_r != acc_addr[EBW_PAGE_LSB +: 7]);
  assign need_gap    = is_read & is_mem &
                       (consecutive_bank_mode_r |
                        (last_valid_r &
                         (cross_bank |
                          (last_read_r & (cross_space |
                                          cross_page)))));

  assign wait_over = (wcnt_r == 4'h0);
  // Two strobe cycles so synchronised ready and data come from inside it
  assign settled   = (age_r == 2'h2);
  assign finish    = strobe_on & wait_over & rdy_s2_r & settled;

  always_comb
  begin
    state_nxt = state_r;
    wcnt_nxt  = wcnt_r;
    case (state_r)
      EBW_ST_IDLE:
        if (acc_req)
          state_nxt = need_gap ? EBW_ST_GAP : EBW_ST_STRB;
      EBW_ST_GAP:
        if (tick)
        begin
          state_nxt = EBW_ST_STRB;
        end
      EBW_ST_STRB:
        if (!wait_over)
          wcnt_nxt = 4'(wcnt_r - 4'h1);
        else if (rdy_s2_r && settled)
          state_nxt = (consecutive_bank_mode_r & ~write_r &
                       (space_r != EBW_SP_IO)) ? EBW_ST_TRAIL
                                               : EBW_ST_DONE;
      EBW_ST_TRAIL:
        if (tick)
          state_nxt = EBW_ST_DONE;
      EBW_ST_DONE:
        state_nxt = EBW_ST_IDLE;
      default:
        state_nxt = EBW_ST_IDLE;
    endcase
    // Count loads as the strobe phase opens; held at zero when gated
    if ((state_r != EBW_ST_STRB) && (state_nxt == EBW_ST_STRB))
      wcnt_nxt = cfg_bus.gen_off ? 4'h0 : cfg_bus.wait_count;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r      <= EBW_ST_IDLE;
      wcnt_r       <= 4'h0;
      addr_r       <= '0;
      space_r      <= EBW_SP_PROG;
      write_r      <= 1'b0;
      wdata_r      <= '0;
      rdata_r      <= '0;
      last_valid_r <= 1'b0;
      last_read_r  <= 1'b0;
      last_prog_r  <= 1'b0;
      last_msb_r   <= 1'b0;
      last_page_r  <= 7'h00;
      age_r        <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      wcnt_r  <= wcnt_nxt;
      age_r   <= ~strobe_on ? 2'h0 :
                 settled ? age_r : 2'(age_r + 2'h1);
      if (take)
      begin
        addr_r  <= acc_addr;
        space_r <= ebw_space_t'(acc_space);
        write_r <= acc_write;
        wdata_r <= acc_wdata;
        if (is_mem)
        begin
          last_valid_r <= 1'b1;
          last_read_r  <= is_read;
          last_prog_r  <= (acc_space == EBW_SP_PROG);
          last_msb_r   <= acc_addr[EBW_BANK_BIT];
          last_page_r  <= acc_addr[EBW_PAGE_LSB +: 7];
        end
      end
      if (finish && !write_r)
        rdata_r <= din_s2_r;
    end
  end

  // External pins
  assign strobe_on       = (state_r == EBW_ST_STRB);
  assign ext_addr        = addr_r;
  assign ext_read        = ~write_r;
  assign memory_strobe_n = ~(strobe_on & (space_r != EBW_SP_IO));
  assign io_strobe_n     = ~(strobe_on & (space_r == EBW_SP_IO));
  assign ext_data_o      = wdata_r;
  assign ext_data_oe     = strobe_on & write_r;

  // Core handshake
  assign acc_ack   = take;
  assign acc_done  = (state_r == EBW_ST_DONE);
  assign acc_rdata = rdata_r;

endmodule

// >>> verification/ebw_ext_mem.sv
// Model of the external memory or peripheral on the parallel bus.
// Assumes the block's strobes are active low and ready has a pull-up.
module ebw_ext_mem
  import ebw_pkg::*;
(
  // Clock
  input  wire logic              pclk,
  // Bus from the block
  input  wire logic [EBW_AW-1:0] ext_addr,
  input  wire logic              ext_read,
  input  wire logic              memory_strobe_n,
  input  wire logic              io_strobe_n,
  // Cycles that ready stays low in each strobe
  input  wire logic [7:0]        stall,
  // Answer
  output logic [EBW_DW-1:0]      ext_data_i,
  output logic                   ext_ready
);
  logic              sel;
  logic [7:0]        cnt_r = 8'h0;
  logic [EBW_DW-1:0] last_r = 16'h0;

  assign sel = !memory_strobe_n || !io_strobe_n;
  // Pulled up while idle; slow device holds it low
  assign ext_ready = !sel || (cnt_r >= stall);
  // Released bus shows the inverse of the last word
  assign ext_data_i = (sel && ext_read) ? (ext_addr[15:0] ^ 16'h5a5a)
                                        : ~last_r;

  always @(posedge pclk)
  begin
    cnt_r <= sel ? cnt_r + 8'h1 : 8'h0;
    if (sel && ext_read)
      last_r <= ext_data_i;
  end
endmodule

// >>> verification/ebw_top_sva.sv
// Checker for the external bus cycle controller's ports.
// Assumes one clock domain, pclk, with active-low presetn.
module ebw_top_sva
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  // Core access port
  input  wire logic        acc_req,
  input  wire logic        acc_ack,
  input  wire logic        acc_done,
  // External bus
  input  wire logic        ext_read,
  input  wire logic        memory_strobe_n,
  input  wire logic        io_strobe_n,
  input  wire logic        ext_data_oe,
  input  wire logic        ext_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take;
    acc_ack;
  endsequence
  sequence s_slow;
    (!ext_ready && !memory_strobe_n) [*4];
  endsequence

  strobe_excl_a: assert property (!(!memory_strobe_n && !io_strobe_n))
    else $error("both strobes low");
  ack_req_a: assert property (acc_ack |-> acc_req)
    else $error("ack without request");
  ack_busy_a: assert property (s_take |=> !acc_ack [*2])
    else $error("request taken while busy");
  done_pulse_a: assert property (acc_done |=> !acc_done)
    else $error("done longer than one cycle");
  done_bound_a: assert property (s_take |-> ##[2:60] acc_done)
    else $error("access did not finish in time");
  no_early_a: assert property (s_take |=> !acc_done)
    else $error("access finished too early");
  ready_hold_a: assert property (s_slow |=> !acc_done)
    else $error("finished while ready low");
  ctl_read_a: assert property (psel && penable && !pwrite &&
    paddr == 12'h0ac |-> prdata[31:1] == 31'h0)
    else $error("control upper bits not zero");
  oe_write_a: assert property (ext_data_oe |-> !ext_read)
    else $error("data driven during read");
endmodule

bind ebw_top ebw_top_sva i_ebw_top_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .acc_req(acc_req), .acc_ack(acc_ack),
  .acc_done(acc_done), .ext_read(ext_read),
  .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n),
  .ext_data_oe(ext_data_oe), .ext_ready(ext_ready));

// >>> verification/ebw_top_tb.sv
// Self-checking bench for the external bus cycle controller.
// Assumes ebw_ext_mem answers reads with address xor 5a5a.
module ebw_top_tb
  import ebw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CFG  = {2'h0, EBW_IDX_WAIT_CFG, 2'h0};
  localparam logic [11:0] A_BANK = {2'h0, EBW_IDX_BANK_CTL, 2'h0};
  localparam logic [11:0] A_CTL  = {2'h0, EBW_IDX_WAIT_CTL, 2'h0};
  localparam logic [11:0] A_ST   = {2'h0, EBW_IDX_STATUS, 2'h0};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              acc_req, acc_write, acc_ack, acc_done, ext_read;
  logic [1:0]        acc_space;
  logic [EBW_AW-1:0] acc_addr, ext_addr;
  logic [EBW_DW-1:0] acc_wdata, acc_rdata, ext_data_o, ext_data_i, dat;
  logic              memory_strobe_n, io_strobe_n, ext_data_oe, ext_ready;
  logic              bus_clock_output, iack_off;
  logic [7:0]        stall;
  int                errors, check_count, lat;

  ebw_top i_ebw_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_req(acc_req), .acc_space(acc_space), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .ext_addr(ext_addr),
    .ext_read(ext_read), .memory_strobe_n(memory_strobe_n),
    .io_strobe_n(io_strobe_n), .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i),
    .ext_ready(ext_ready), .bus_clock_output(bus_clock_output),
    .iack_off(iack_off));
  ebw_ext_mem i_ebw_ext_mem (.pclk(pclk), .ext_addr(ext_addr),
    .ext_read(ext_read), .memory_strobe_n(memory_strobe_n),
    .io_strobe_n(io_strobe_n), .stall(stall), .ext_data_i(ext_data_i),
    .ext_ready(ext_ready));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_rng(string name, int lo, int hi, int seen);
    check_count++;
    if (seen < lo || seen > hi)
    begin
      errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, seen);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One core access; l counts edges from take to done
  task automatic acc(logic [1:0] sp, logic wr, logic [22:0] a,
                     output int l, output logic [15:0] q);
    int n;
    n = 0;
    l = 0;
    acc_req <= 1'b1;
    acc_space <= sp;
    acc_write <= wr;
    acc_addr <= a;
    acc_wdata <= ~a[15:0];
    do
      @(negedge pclk);
    while (acc_ack !== 1'b1 && n++ < 50);
    @(posedge pclk);
    acc_req <= 1'b0;
    do
    begin
      @(posedge pclk);
      l++;
      @(negedge pclk);
    end
    while (acc_done !== 1'b1 && l < 200);
    q = acc_rdata;
    @(posedge pclk);
  endtask

  task automatic run(logic [1:0] sp, logic wr, logic [22:0] a, int lo, int hi);
    acc(sp, wr, a, lat, dat);
    chk_rng("latency", lo, hi, lat);
    chk("ext_addr", {9'h0, a}, {9'h0, ext_addr});
    if (wr)
      chk("ext_data_o", {16'h0, ~a[15:0]}, {16'h0, ext_data_o});
    if (!wr)
      chk("rdata", {16'h0, a[15:0] ^ 16'h5a5a}, {16'h0, dat});
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    finish_test();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, acc_req, acc_write} = 6'h0;
    {paddr, pwdata, acc_space, acc_addr, acc_wdata, stall} = '0;
    errors = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, A_CFG, 0, rd); chk("wait_cfg", 32'h7fff, rd);
    apb(0, A_BANK, 0, rd); chk("bank_ctl", 32'h7000, rd);
    apb(0, A_CTL, 0, rd); chk("wait_ctl", 32'h0, rd);
    apb(0, A_ST, 0, rd); chk("gen_off", 32'h0, {31'h0, rd[0]});
    chk("iack_off", 32'h1, {31'h0, iack_off});
    run(EBW_SP_DATA, 0, 23'h000010, 8, 8);
    apb(1, A_CTL, 32'hfffffffe, rd);
    apb(0, A_CTL, 0, rd); chk("wait_ctl", 32'h0, rd);
    apb(1, A_BANK, 0, rd); chk("iack_off", 32'h0, {31'h0, iack_off});
    apb(0, 12'h0f0, 0, rd); chk("slverr", 32'h1, {31'h0, pslverr});
    apb(1, A_CFG, 32'h14e5, rd);
    run(EBW_SP_IO, 1, 23'h009000, 3, 3);
    run(EBW_SP_DATA, 1, 23'h008000, 3, 3);
    run(EBW_SP_DATA, 1, 23'h000100, 4, 4);
    run(EBW_SP_PROG, 1, 23'h018000, 5, 5);
    run(EBW_SP_PROG, 1, 23'h010000, 6, 6);
    apb(1, A_CFG, 32'h94e5, rd);
    run(EBW_SP_PROG, 1, 23'h400000, 5, 5);
    run(EBW_SP_PROG, 1, 23'h3f8000, 6, 6);
    apb(1, A_CTL, 32'hffffffff, rd);
    apb(0, A_CTL, 0, rd); chk("wait_ctl", 32'h1, rd);
    run(EBW_SP_PROG, 1, 23'h400000, 9, 9);
    apb(1, A_CFG, 32'h0e00, rd);
    run(EBW_SP_DATA, 1, 23'h008000, 15, 15);
    apb(1, A_CTL, 0, rd);
    apb(1, A_CFG, 0, rd);
    apb(0, A_ST, 0, rd); chk("gen_off", 32'h1, {31'h0, rd[0]});
    run(EBW_SP_DATA, 1, 23'h000000, 3, 3);
    run(EBW_SP_DATA, 0, 23'h000010, 3, 3);
    run(EBW_SP_DATA, 0, 23'h008010, 4, 4);
    run(EBW_SP_DATA, 0, 23'h008020, 3, 3);
    run(EBW_SP_PROG, 0, 23'h008000, 4, 4);
    run(EBW_SP_PROG, 0, 23'h018000, 4, 4);
    run(EBW_SP_PROG, 0, 23'h018004, 3, 3);
    run(EBW_SP_IO, 0, 23'h000004, 3, 3);
    apb(1, A_BANK, 32'h8000, rd);
    run(EBW_SP_PROG, 0, 23'h018008, 5, 5);
    apb(1, A_BANK, 0, rd);
    apb(1, A_CFG, 32'h0003, rd);
    stall <= 8'd12;
    run(EBW_SP_PROG, 0, 23'h01000c, 16, 16);
    stall <= 8'd0;
    finish_test();
  end
endmodule
